//--- rtl/ttp_pkg.sv
// Package for the tape test panel control block
package ttp_pkg;
  // Register byte offsets
  localparam logic [3:0] TTP_OFS_CTRL = 4'h0;
  localparam logic [3:0] TTP_OFS_STAT = 4'h4;
  localparam logic [3:0] TTP_OFS_IRQ_STAT = 4'h8;
  localparam logic [3:0] TTP_OFS_IRQ_MASK = 4'hC;
  // Control field positions
  localparam int TTP_CTRL_LAMP_TEST = 0;
  // Interrupt bit positions
  localparam int TTP_IRQ_PANEL_ON = 0;
  localparam int TTP_IRQ_PANEL_OFF = 1;
  localparam int TTP_IRQ_TAPE_END = 2;
  localparam int TTP_IRQ_LOAD_PT = 3;
  localparam int TTP_IRQ_SKEW = 4;
  localparam int TTP_IRQ_W = 5;
  // Reset values
  localparam logic [31:0] TTP_CTRL_RST = 32'h0000_0000;
  localparam logic [TTP_IRQ_W-1:0] TTP_IRQ_RST = 5'h00;
  // Shuttle leg length
  localparam int TTP_LEG_MS = 200;
  localparam int TTP_CLK_HZ = 20_000_000;
  localparam int TTP_LEG_CYC = TTP_LEG_MS * (TTP_CLK_HZ / 1000);

  // Motion modes, one-hot
  typedef enum logic [4:0] {
    TTP_HALT = 5'h01,
    TTP_SHUTTLE_FWD = 5'h02,
    TTP_SHUTTLE_REV = 5'h04,
    TTP_FAST_FWD = 5'h08,
    TTP_RUN_REV = 5'h10
  } ttp_mode_e;

  // Operator buttons
  typedef struct packed {
    logic shuttle;
    logic fast_fwd;
    logic rev_run;
    logic fwd_run;
    logic halt;
    logic pattern_write;
    logic test_mode;
    logic on_line;
  } ttp_btn_s;

  // Motion request to the sequencer
  typedef struct packed {
    logic run_fwd;
    logic run_rev;
    logic fast;
  } ttp_motion_s;

  // Indicator lamps
  typedef struct packed {
    logic skew;
    logic dense_format_lamp;
    logic tape_end;
    logic load_point;
    logic pattern_write;
    logic test_mode;
  } ttp_lamp_s;
endpackage

//--- rtl/ttp_panel.sv
// Tape test panel control: buttons to motion, write test and lamps
`timescale 1ns/1ns
`default_nettype none
module ttp_panel #(
  parameter int CHANNELS = 9,
  parameter int LEG_CYC = ttp_pkg::TTP_LEG_CYC
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire ttp_pkg::ttp_btn_s btn_i,
  input wire logic off_line_i,
  input wire logic dense_sel_i,
  input wire logic tape_end_marker_i,
  input wire logic load_point_i,
  input wire logic write_gate_sel_i,
  input wire logic read_skew_i,
  input wire logic write_skew_i,
  input wire logic read_gate_i,
  input wire logic write_gate_i,
  input wire logic ref_freq_i,
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output logic irq_o,
  output ttp_pkg::ttp_motion_s motion_o,
  output logic [CHANNELS-1:0] write_ones_o,
  output logic skew_gate_tp_o,
  output ttp_pkg::ttp_lamp_s lamp_o
);
  import ttp_pkg::*;

  localparam int NSYNC = 17;

  //////////////////////////////////////////////////////////////////////////////
  // Input synchronisers: all panel and tape pins are asynchronous to the clock
  logic [NSYNC-1:0] raw;
  logic [NSYNC-1:0] sync1_r;
  logic [NSYNC-1:0] sync2_r;
  assign raw = {btn_i, off_line_i, dense_sel_i, tape_end_marker_i, load_point_i,
                write_gate_sel_i, read_skew_i, write_skew_i, read_gate_i,
                write_gate_i};

  // Two-stage synchroniser, first stage read only by the second
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= raw;
      sync2_r <= sync1_r;
    end
  end

  ttp_btn_s btn;
  logic off_line, dense_sel, tape_end, load_pt, wgate_sel;
  logic rskew, wskew, rgate, wgate;
  assign {btn, off_line, dense_sel, tape_end, load_pt, wgate_sel,
          rskew, wskew, rgate, wgate} = sync2_r;

  // Reference frequency on its own synchroniser; a fast reference will alias
  logic fr_s1_r, fr_s2_r;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fr_s1_r <= 1'b0;
      fr_s2_r <= 1'b0;
    end else begin
      fr_s1_r <= ref_freq_i;
      fr_s2_r <= fr_s1_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Edge detection on the momentary buttons
  ttp_btn_s btn_d_r;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      btn_d_r <= '0;
    end else begin
      btn_d_r <= btn;
    end
  end
  ttp_btn_s press;
  assign press = btn & ~btn_d_r;

  //////////////////////////////////////////////////////////////////////////////
  // Test mode latch
  logic panel_on_r;
  logic panel_on_nxt;
  logic can_enter;
  assign can_enter = off_line && btn.halt;

  always_comb begin
    panel_on_nxt = panel_on_r;
    if (!panel_on_r) begin
      if (press.test_mode && can_enter) begin
        panel_on_nxt = 1'b1;
      end
    end else begin
      if (press.test_mode || press.on_line || !off_line) begin
        panel_on_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      panel_on_r <= 1'b0;
    end else begin
      panel_on_r <= panel_on_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Motion mode machine
  ttp_mode_e mode_r;
  ttp_mode_e mode_nxt;
  logic fwd_run_r;
  logic fwd_run_nxt;
  logic [31:0] leg_cnt_r;
  logic leg_done;
  assign leg_done = (leg_cnt_r == 32'(LEG_CYC - 1));

  always_comb begin
    mode_nxt = mode_r;
    fwd_run_nxt = fwd_run_r;
    if (press.shuttle) begin
      mode_nxt = TTP_SHUTTLE_FWD;
      fwd_run_nxt = 1'b0;
    end else if (press.fast_fwd) begin
      mode_nxt = TTP_FAST_FWD;
      fwd_run_nxt = 1'b0;
    end else if (press.rev_run) begin
      mode_nxt = TTP_RUN_REV;
      fwd_run_nxt = 1'b0;
    end else if (press.fwd_run) begin
      mode_nxt = TTP_HALT;
      fwd_run_nxt = 1'b1;
    end else begin
      case (mode_r)
        TTP_HALT: begin
          // Forward run stops at end marker
          if (tape_end) begin
            fwd_run_nxt = 1'b0;
          end
        end
        TTP_SHUTTLE_FWD: begin
          if (leg_done || tape_end) begin
            mode_nxt = TTP_SHUTTLE_REV;
          end
        end
        TTP_SHUTTLE_REV: begin
          if (leg_done || load_pt) begin
            mode_nxt = TTP_SHUTTLE_FWD;
          end
        end
        TTP_FAST_FWD: begin
          if (tape_end) begin
            mode_nxt = TTP_HALT;
          end
        end
        TTP_RUN_REV: begin
          if (load_pt) begin
            mode_nxt = TTP_HALT;
          end
        end
        default: begin
          mode_nxt = TTP_HALT;
        end
      endcase
    end
    // Halt or lost panel cancels all
    if (btn.halt || !panel_on_r) begin
      mode_nxt = TTP_HALT;
      fwd_run_nxt = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_r <= TTP_HALT;
      fwd_run_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      fwd_run_r <= fwd_run_nxt;
    end
  end

  // Shuttle leg timer restarts on every direction change
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      leg_cnt_r <= '0;
    end else if (mode_nxt != mode_r || leg_done) begin
      leg_cnt_r <= '0;
    end else begin
      leg_cnt_r <= leg_cnt_r + 32'h0000_0001;
    end
  end

  // Motion request outputs from flops
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      motion_o <= '0;
    end else begin
      motion_o.run_fwd <= fwd_run_nxt || mode_nxt == TTP_SHUTTLE_FWD || mode_nxt == TTP_FAST_FWD;
      motion_o.run_rev <= mode_nxt == TTP_SHUTTLE_REV || mode_nxt == TTP_RUN_REV;
      motion_o.fast <= mode_nxt == TTP_FAST_FWD;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pattern write test
  logic pw_arm_r;
  logic pw_arm_nxt;
  always_comb begin
    pw_arm_nxt = pw_arm_r;
    // Armed while halted in test mode
    if (press.pattern_write && panel_on_r && btn.halt) begin
      pw_arm_nxt = 1'b1;
    end else if (!panel_on_r || (!btn.halt && !fwd_run_nxt)) begin
      pw_arm_nxt = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pw_arm_r <= 1'b0;
    end else begin
      pw_arm_r <= pw_arm_nxt;
    end
  end

  logic pw_active;
  // Next state, in step with motion
  assign pw_active = pw_arm_nxt && fwd_run_nxt;

  // All channels toggle with the reference for all ones
  logic [CHANNELS-1:0] ones_r;
  genvar gi;
  generate
    for (gi = 0; gi < CHANNELS; gi++) begin : g_ch
      always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          ones_r[gi] <= 1'b0;
        end else begin
          ones_r[gi] <= pw_active && fr_s2_r;
        end
      end
    end
  endgenerate
  assign write_ones_o = ones_r;

  //////////////////////////////////////////////////////////////////////////////
  // Lamps and test point
  logic lamp_test_r;
  logic skew_lamp;
  logic skew_gate;
  // Skew against the gate in use
  assign skew_lamp = wgate_sel ? wskew : rskew;
  assign skew_gate = wgate_sel ? wgate : rgate;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lamp_o <= '0;
      skew_gate_tp_o <= 1'b0;
    end else begin
      skew_gate_tp_o <= skew_gate;
      lamp_o.skew <= skew_lamp || lamp_test_r;
      lamp_o.dense_format_lamp <= dense_sel || lamp_test_r;
      lamp_o.tape_end <= tape_end || lamp_test_r;
      lamp_o.load_point <= load_pt || lamp_test_r;
      lamp_o.pattern_write <= pw_active || lamp_test_r;
      lamp_o.test_mode <= panel_on_nxt || lamp_test_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register port and interrupts
  logic [TTP_IRQ_W-1:0] irq_stat_r;
  logic [TTP_IRQ_W-1:0] irq_mask_r;
  logic [TTP_IRQ_W-1:0] ev;
  logic tape_end_d_r, load_pt_d_r, skew_d_r;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tape_end_d_r <= 1'b0;
      load_pt_d_r <= 1'b0;
      skew_d_r <= 1'b0;
    end else begin
      tape_end_d_r <= tape_end;
      load_pt_d_r <= load_pt;
      skew_d_r <= skew_lamp;
    end
  end

  assign ev[TTP_IRQ_PANEL_ON] = panel_on_nxt && !panel_on_r;
  assign ev[TTP_IRQ_PANEL_OFF] = !panel_on_nxt && panel_on_r;
  assign ev[TTP_IRQ_TAPE_END] = tape_end && !tape_end_d_r;
  assign ev[TTP_IRQ_LOAD_PT] = load_pt && !load_pt_d_r;
  assign ev[TTP_IRQ_SKEW] = skew_lamp && !skew_d_r;

  // Write-one-to-clear; a new event in the same cycle survives
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_stat_r <= TTP_IRQ_RST;
    end else if (wr_i && addr_i == TTP_OFS_IRQ_STAT) begin
      irq_stat_r <= (irq_stat_r & ~wdata_i[TTP_IRQ_W-1:0]) | ev;
    end else begin
      irq_stat_r <= irq_stat_r | ev;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_mask_r <= TTP_IRQ_RST;
      lamp_test_r <= TTP_CTRL_RST[TTP_CTRL_LAMP_TEST];
    end else if (wr_i) begin
      if (addr_i == TTP_OFS_IRQ_MASK) begin
        irq_mask_r <= wdata_i[TTP_IRQ_W-1:0];
      end
      if (addr_i == TTP_OFS_CTRL) begin
        lamp_test_r <= wdata_i[TTP_CTRL_LAMP_TEST];
      end
    end
  end

  assign irq_o = |(irq_stat_r & irq_mask_r);

  // Read data valid the cycle after the strobe, zero otherwise
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= '0;
    end else if (rd_i) begin
      case (addr_i)
        TTP_OFS_CTRL: rdata_o <= {31'h0, lamp_test_r};
        TTP_OFS_STAT: rdata_o <= {21'h0, pw_active, fwd_run_r, mode_r, panel_on_r,
                                  tape_end, load_pt, skew_lamp};
        TTP_OFS_IRQ_STAT: rdata_o <= {27'h0, irq_stat_r};
        TTP_OFS_IRQ_MASK: rdata_o <= {27'h0, irq_mask_r};
        default: rdata_o <= '0;
      endcase
    end else begin
      rdata_o <= '0;
    end
  end
endmodule
`default_nettype wire

//--- dv/ttp_panel_props.sv
// Port-level checker for the tape test panel control
`timescale 1ns/1ns
`default_nettype none
module ttp_panel_props #(
  parameter int CHANNELS = 9
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire ttp_pkg::ttp_btn_s btn_i,
  input wire logic off_line_i,
  input wire logic dense_sel_i,
  input wire logic tape_end_marker_i,
  input wire logic load_point_i,
  input wire logic write_gate_sel_i,
  input wire logic write_gate_i,
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire ttp_pkg::ttp_motion_s motion_o,
  input wire logic [CHANNELS-1:0] write_ones_o,
  input wire logic skew_gate_tp_o,
  input wire ttp_pkg::ttp_lamp_s lamp_o
);
  import ttp_pkg::*;
  logic lt_r;
  logic lt2_r;
  // Lamp test lights every lamp, so write_fwd_a and online_off_a step aside while it is on
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lt_r <= 1'b0;
      lt2_r <= 1'b0;
    end else begin
      if (wr_i && addr_i == TTP_OFS_CTRL) lt_r <= wdata_i[TTP_CTRL_LAMP_TEST];
      lt2_r <= lt_r;
    end
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////////////////////////////
  dir_excl_a: assert property (!(motion_o.run_fwd && motion_o.run_rev))
    else $error("motion both ways");
  fast_fwd_a: assert property (motion_o.fast |-> motion_o.run_fwd)
    else $error("fast without forward");
  halt_stop_a: assert property (btn_i.halt [*4] |=> motion_o == '0)
    else $error("motion while halted");
  ones_all_a: assert property (write_ones_o == '0 || &write_ones_o)
    else $error("channels differ");
  ones_lamp_a: assert property (|write_ones_o |-> lamp_o.pattern_write)
    else $error("ones without lamp");
  write_fwd_a: assert property (lamp_o.pattern_write && !lt_r && !lt2_r
    |-> motion_o.run_fwd)
    else $error("write test off forward");
  dense_lamp_a: assert property (dense_sel_i [*4] |=> lamp_o.dense_format_lamp)
    else $error("dense lamp dark");
  end_lamp_a: assert property (tape_end_marker_i [*4] |=> lamp_o.tape_end)
    else $error("end lamp dark");
  load_lamp_a: assert property (load_point_i [*4] |=> lamp_o.load_point)
    else $error("load lamp dark");
  gate_tp_a: assert property ((write_gate_sel_i && write_gate_i) [*4]
    |=> skew_gate_tp_o)
    else $error("test point low");
  online_off_a: assert property (!off_line_i [*5] ##0 !lt_r && !lt2_r
    |=> !lamp_o.test_mode)
    else $error("panel on line");
endmodule
bind ttp_panel ttp_panel_props #(.CHANNELS(CHANNELS)) ttp_panel_props_inst (.ref_clk_i, .rst_n_i,
  .btn_i, .off_line_i, .dense_sel_i, .tape_end_marker_i, .load_point_i, .write_gate_sel_i,
  .write_gate_i, .addr_i, .wdata_i, .wr_i, .motion_o, .write_ones_o, .skew_gate_tp_o, .lamp_o);
`default_nettype wire

//--- dv/ttp_operator.sv
// Operator model: pushbuttons pressed and held by hand
`timescale 1ns/1ns
`default_nettype none
module ttp_operator (
  input wire logic ref_clk_i,
  output wire ttp_pkg::ttp_btn_s btn_o
);
  import ttp_pkg::*;
  logic [7:0] btn_r;
  assign btn_o = btn_r;
  // Halt rests engaged, as a transport is left when taken off line
  initial btn_r = 8'h08;
  // Momentary press; motion buttons are interlocked and pop the halt button
  task automatic press(input int b);
    btn_r[b] <= 1'b1;
    if (b >= 4) btn_r[3] <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    btn_r[b] <= 1'b0;
  endtask
  // Held button, such as halt
  task automatic set(input int b, input logic v);
    btn_r[b] <= v;
  endtask
endmodule
`default_nettype wire

//--- dv/ttp_panel_tb.sv
// Self-checking testbench for the tape test panel control
`timescale 1ns/1ns
`default_nettype none
module ttp_panel_tb;
  import ttp_pkg::*;
  localparam int LEG = 16;
  localparam int SHU = 7, FST = 6, REV = 5, FWD = 4, HLT = 3, PW = 2, TM = 1, OL = 0;
  logic clk, rst_n, off_line, dense, tend, lpt, gsel, rskew, wskew, wgate, rgate, rfreq, wr, rd;
  logic tp, irq;
  logic [3:0] addr;
  logic [31:0] wdata, rdata, v;
  logic [8:0] ones;
  ttp_btn_s btn;
  ttp_motion_s motion;
  ttp_lamp_s lamp;
  int fail_count, comparisons;
  ttp_operator ttp_operator_inst (.ref_clk_i(clk), .btn_o(btn));
  ttp_panel #(.CHANNELS(9), .LEG_CYC(LEG)) ttp_panel_inst (.ref_clk_i(clk), .rst_n_i(rst_n),
    .btn_i(btn), .off_line_i(off_line), .dense_sel_i(dense), .tape_end_marker_i(tend),
    .load_point_i(lpt), .write_gate_sel_i(gsel), .read_skew_i(rskew), .write_skew_i(wskew),
    .read_gate_i(rgate), .write_gate_i(wgate), .ref_freq_i(rfreq), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .irq_o(irq), .motion_o(motion),
    .write_ones_o(ones), .skew_gate_tp_o(tp), .lamp_o(lamp));
  ////////////////////////////////////////////////////////////////
  // Clock at 20 MHz
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task automatic chb(input logic got, input logic exp, input string m);
    chk(32'(got), 32'(exp), m);
  endtask
  task automatic chm(input logic [2:0] e);
    chk(32'(motion), 32'(e), "motion");
  endtask
  task automatic st(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Press and let the two sync flops and the output register catch up
  task automatic pr(input int b);
    ttp_operator_inst.press(b);
    st(6);
  endtask
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rreg(input logic [3:0] a);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic final_report;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rreg(TTP_OFS_CTRL);
    chk(v, TTP_CTRL_RST, "ctrl reset");
    rreg(4'h2);
    chk(v, 32'h0, "unmapped read");
    wreg(TTP_OFS_CTRL, 32'h1);
    st(2);
    chk(32'(lamp), 32'h3F, "lamp test");
    rreg(TTP_OFS_CTRL);
    chk(v, 32'h1, "ctrl readback");
    wreg(TTP_OFS_CTRL, 32'h0);
  endtask
  task automatic t_panel;
    wreg(TTP_OFS_IRQ_MASK, 32'h1F);
    off_line <= 1'b0;
    pr(TM);
    chb(lamp.test_mode, 1'b0, "panel on line");
    off_line <= 1'b1;
    ttp_operator_inst.set(HLT, 1'b0);
    pr(TM);
    chb(lamp.test_mode, 1'b0, "panel without halt");
    ttp_operator_inst.set(HLT, 1'b1);
    pr(TM);
    chb(lamp.test_mode, 1'b1, "panel off");
    rreg(TTP_OFS_STAT);
    chk(32'(v[8:3]), 32'h3, "status");
    chb(irq, 1'b1, "irq raise");
    wreg(TTP_OFS_IRQ_MASK, 32'h0);
    chb(irq, 1'b0, "irq mask");
    wreg(TTP_OFS_IRQ_MASK, 32'h1F);
    wreg(TTP_OFS_IRQ_STAT, 32'h1F);
    chb(irq, 1'b0, "irq clear");
  endtask
  task automatic t_motion;
    pr(PW);
    rfreq <= 1'b1;
    pr(FWD);
    chm(3'b100);
    chb(lamp.pattern_write, 1'b1, "write lamp");
    chk(32'(ones), 32'h1FF, "ones");
    rfreq <= 1'b0;
    st(4);
    chk(32'(ones), 32'h0, "ones gated");
    pr(FST);
    chm(3'b101);
    chb(lamp.pattern_write, 1'b0, "write off fast");
    tend <= 1'b1;
    st(6);
    chm(3'b000);
    chb(lamp.tape_end, 1'b1, "end lamp");
    tend <= 1'b0;
    pr(REV);
    chm(3'b010);
    lpt <= 1'b1;
    st(6);
    chm(3'b000);
    chb(lamp.load_point, 1'b1, "load lamp");
    lpt <= 1'b0;
    pr(FWD);
    tend <= 1'b1;
    st(6);
    chm(3'b000);
    tend <= 1'b0;
  endtask
  task automatic t_shuttle;
    pr(SHU);
    chm(3'b100);
    v = 32'h0;
    repeat (LEG * 3) begin
      @(posedge clk);
      #1 if (motion.run_rev) v = 32'h1;
    end
    chk(v, 32'h1, "no reverse leg");
    ttp_operator_inst.set(HLT, 1'b1);
    st(6);
    chm(3'b000);
  endtask
  task automatic t_lamps;
    dense <= 1'b1;
    rskew <= 1'b1;
    rgate <= 1'b1;
    st(6);
    chb(lamp.dense_format_lamp, 1'b1, "dense");
    chb(lamp.skew, 1'b1, "read skew");
    chb(tp, 1'b1, "read gate test point");
    gsel <= 1'b1;
    wgate <= 1'b1;
    rgate <= 1'b0;
    st(6);
    chb(lamp.skew, 1'b0, "write gate skew");
    chb(tp, 1'b1, "gate test point");
    wskew <= 1'b1;
    st(6);
    chb(lamp.skew, 1'b1, "write skew");
    {dense, rskew, wskew, gsel, wgate} <= '0;
  endtask
  task automatic t_leave;
    pr(TM);
    chb(lamp.test_mode, 1'b0, "second press");
    pr(TM);
    chb(lamp.test_mode, 1'b1, "panel reentered");
    pr(OL);
    chb(lamp.test_mode, 1'b0, "on line press");
    // Write test pressed with the panel off must not arm
    pr(PW);
    pr(TM);
    pr(FWD);
    chm(3'b100);
    chb(lamp.pattern_write, 1'b0, "write test panel off");
    pr(PW);
    chb(lamp.pattern_write, 1'b0, "write test not halted");
    ttp_operator_inst.set(HLT, 1'b1);
    st(6);
    chm(3'b000);
  endtask
  // Main sequence
  initial begin
    {off_line, dense, tend, lpt, gsel, rskew, wskew, wgate, rgate, rfreq, wr, rd} = '0;
    off_line = 1'b1;
    addr = '0;
    wdata = '0;
    rst_n = 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    st(1);
    t_regs();
    t_panel();
    t_motion();
    t_shuttle();
    t_lamps();
    t_leave();
    final_report();
  end
  // Watchdog well beyond the expected few hundred cycles
  initial begin
    #200000;
    fail_count++;
    final_report();
  end
endmodule
`default_nettype wire
